/* logic/cpu_bus_ctrl_config.sv */
// Configuration bank, coprocessor sideband and fast graphics strobes
//////////////////////////////////////////////////////////////////////////
// What this block does
// - Coprocessor busy input drives CPU busy
// - Drive active-low coprocessor exception interrupt line
// - Coprocessor reset follows third system reset
// - Port write gives fixed coprocessor reset pulse
// - Fast request sampled only when enabled
// - Default cycles: graphics strobe equals channel strobe
// - Fast cycles: only graphics strobe asserted
// - Graphics strobe latches channel address bits
// - Index port then data port register access
// - Version register read-only, fixed revision code
// - Speed bits 1:0 select processor clock
// - Speed bit 4 reports coprocessor presence
// - Speed bit 5 selects coprocessor ready source
// - Bit 6 delays wide sampling, adds wait
// - Bit 6 delays and stretches channel strobe
//////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_ctrl_config #(
  parameter int unsigned RESET_PULSE_CYCLES = cfg_bank_pkg::RESET_PULSE_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [9:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_rdata_oe_o,
  input wire logic coproc_busy_n_i,
  input wire logic coproc_error_n_i,
  input wire logic coproc_present_i,
  input wire logic coproc_cycle_i,
  input wire logic coproc_ready_n_i,
  input wire logic system_reset_third_i,
  output logic cpu_busy_n_o,
  output logic coproc_exception_n_o,
  output logic coproc_reset_out_o,
  output logic cpu_ready_n_o,
  output logic [1:0] cpu_clock_sel_o,
  input wire logic local_wide_mem_n_i,
  output logic local_wide_mem_sampled_n_o,
  output logic bus_wait_insert_o,
  input wire logic channel_cmd_req_i,
  input wire logic fast_gfx_request_n_i,
  output logic channel_command_n_o,
  output logic fast_gfx_command_n_o,
  input wire logic [15:0] channel_addr_i,
  output logic [15:0] peripheral_address_bus_o,
  output logic matched_mem_enable_o,
  output logic data_ready_extend_o
);
  //////////////////////////////////////////////////////////////////////////
  // Types and helpers

  typedef struct packed {
    logic [7:0] index;
    logic [1:0] clk_sel;
    logic ready_from_coproc;
    logic delay_mode;
    logic present;
    logic strap_taken;
    logic [2:0] option;
    logic [7:0] rdata;
    logic rdata_oe;
    logic busy_n;
    logic excpt_n;
    logic reset_out;
    logic reset_kick;
    logic ready_n;
    logic ready_done;
    logic req_d1;
    logic req_d2;
    cfg_bank_pkg::cmd_phase_e phase;
    logic chan_cmd_n;
    logic gfx_cmd_n;
    logic [15:0] addr_bus;
    logic wide_d1;
    logic wide_sampled_n;
  } bank_state_s;

  // Port decode shared by the read and write paths
  function automatic logic hit(input logic [9:0] addr, input logic [9:0] port);
    hit = (addr == port);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rst_pipe;
  logic rst_n;

  // Async assert, clocked release so no flop leaves reset mid-edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  //////////////////////////////////////////////////////////////////////////
  // Reset pulse timer

  pulse_timer_if tmr_bus ();

  coproc_reset_timer #(
    .PULSE_CYCLES(RESET_PULSE_CYCLES)
  ) u_reset_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .tmr(tmr_bus.timer)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic

  bank_state_s cur;
  bank_state_s next_cur;
  logic wr_data;
  logic rd_data;
  logic eff_req;
  logic [7:0] speed_view;

  assign tmr_bus.start = cur.reset_kick;

  // Speed register as software sees it; unused bits stay zero
  assign speed_view = {1'b0, cur.delay_mode, cur.ready_from_coproc, cur.present,
                       2'h0, cur.clk_sel};

  // Delay mode: strobe starts one cycle late and ends two late, so it widens
  assign eff_req = cur.delay_mode ? (cur.req_d1 | cur.req_d2) : channel_cmd_req_i;

  assign wr_data = io_wr_i && hit(io_addr_i, cfg_bank_pkg::PORT_DATA);
  assign rd_data = io_rd_i && hit(io_addr_i, cfg_bank_pkg::PORT_DATA);

  always_comb begin
    next_cur = cur;

    // Presence strap is caught once, on the first cycle after release
    if (!cur.strap_taken) begin
      next_cur.present = coproc_present_i;
      next_cur.strap_taken = 1'b1;
    end

    // Index port holds the register selector
    if (io_wr_i && hit(io_addr_i, cfg_bank_pkg::PORT_INDEX)) begin
      next_cur.index = io_wdata_i;
    end

    // Data port writes; version register and reserved bits ignore them
    if (wr_data) begin
      case (cur.index)
        cfg_bank_pkg::IDX_SPEED: begin
          next_cur.clk_sel = io_wdata_i[cfg_bank_pkg::SPD_CLK_LSB +: 2];
          next_cur.ready_from_coproc = io_wdata_i[cfg_bank_pkg::SPD_READY_BIT];
          next_cur.delay_mode = io_wdata_i[cfg_bank_pkg::SPD_DELAY_BIT];
        end
        cfg_bank_pkg::IDX_OPTION: begin
          next_cur.option = io_wdata_i[2:0];
        end
        default: begin
        end
      endcase
    end

    // Reads answer one cycle later; unknown indices read zero
    next_cur.rdata_oe = io_rd_i && (hit(io_addr_i, cfg_bank_pkg::PORT_INDEX) || rd_data);
    next_cur.rdata = 8'h00;
    if (io_rd_i && hit(io_addr_i, cfg_bank_pkg::PORT_INDEX)) begin
      next_cur.rdata = cur.index;
    end else if (rd_data) begin
      case (cur.index)
        cfg_bank_pkg::IDX_VERSION: next_cur.rdata = {6'h00, cfg_bank_pkg::VERSION_REV};
        cfg_bank_pkg::IDX_SPEED: next_cur.rdata = speed_view;
        cfg_bank_pkg::IDX_OPTION: next_cur.rdata = {5'h00, cur.option};
        default: next_cur.rdata = 8'h00;
      endcase
    end

    // Sideband pass-through toward the CPU and interrupt controller
    next_cur.busy_n = coproc_busy_n_i;
    next_cur.excpt_n = coproc_error_n_i;

    // Coprocessor reset: system reset or the timed pulse
    next_cur.reset_kick = io_wr_i && hit(io_addr_i, cfg_bank_pkg::PORT_COPROC_RESET);
    next_cur.reset_out = system_reset_third_i || tmr_bus.active;

    // Ready for coprocessor cycles, from the coprocessor or a one-cycle local pulse
    if (!coproc_cycle_i) begin
      next_cur.ready_n = 1'b1;
      next_cur.ready_done = 1'b0;
    end else if (cur.ready_from_coproc) begin
      next_cur.ready_n = coproc_ready_n_i;
    end else begin
      next_cur.ready_n = cur.ready_done;
      next_cur.ready_done = 1'b1;
    end

    // Wide-memory indication, sampled one clock later in delay mode
    next_cur.wide_d1 = local_wide_mem_n_i;
    next_cur.wide_sampled_n = cur.delay_mode ? cur.wide_d1 : local_wide_mem_n_i;

    // Command request delay line
    next_cur.req_d1 = channel_cmd_req_i;
    next_cur.req_d2 = cur.req_d1;

    // Cycle type is fixed at strobe start; the request is ignored when disabled
    case (cur.phase)
      cfg_bank_pkg::CMD_IDLE: begin
        if (eff_req && cur.option[cfg_bank_pkg::OPT_FAST_GFX_BIT] && !fast_gfx_request_n_i) begin
          next_cur.phase = cfg_bank_pkg::CMD_FAST;
        end else if (eff_req) begin
          next_cur.phase = cfg_bank_pkg::CMD_DEFAULT;
        end
      end
      cfg_bank_pkg::CMD_DEFAULT,
      cfg_bank_pkg::CMD_FAST: begin
        if (!eff_req) begin
          next_cur.phase = cfg_bank_pkg::CMD_IDLE;
        end
      end
      default: next_cur.phase = cfg_bank_pkg::CMD_IDLE;
    endcase

    // Strobes: graphics on any cycle, channel only on default cycles
    next_cur.gfx_cmd_n = (next_cur.phase == cfg_bank_pkg::CMD_IDLE);
    next_cur.chan_cmd_n = (next_cur.phase != cfg_bank_pkg::CMD_DEFAULT);

    // Latch is transparent while the graphics strobe is low
    if (next_cur.phase != cfg_bank_pkg::CMD_IDLE) begin
      next_cur.addr_bus = channel_addr_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  // Reset values give delay mode and coprocessor ready on, as after power-up
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
      cur.clk_sel <= cfg_bank_pkg::SPD_CLK_RESET;
      cur.ready_from_coproc <= cfg_bank_pkg::SPD_READY_RESET;
      cur.delay_mode <= cfg_bank_pkg::SPD_DELAY_RESET;
      cur.option <= cfg_bank_pkg::OPT_RESET;
      cur.busy_n <= 1'b1;
      cur.excpt_n <= 1'b1;
      cur.reset_out <= 1'b1;
      cur.ready_n <= 1'b1;
      cur.phase <= cfg_bank_pkg::CMD_IDLE;
      cur.chan_cmd_n <= 1'b1;
      cur.gfx_cmd_n <= 1'b1;
      cur.wide_d1 <= 1'b1;
      cur.wide_sampled_n <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign io_rdata_o = cur.rdata;
  assign io_rdata_oe_o = cur.rdata_oe;
  assign cpu_busy_n_o = cur.busy_n;
  assign coproc_exception_n_o = cur.excpt_n;
  assign coproc_reset_out_o = cur.reset_out;
  assign cpu_ready_n_o = cur.ready_n;
  assign cpu_clock_sel_o = cur.clk_sel;
  assign local_wide_mem_sampled_n_o = cur.wide_sampled_n;
  assign bus_wait_insert_o = cur.delay_mode;
  assign channel_command_n_o = cur.chan_cmd_n;
  assign fast_gfx_command_n_o = cur.gfx_cmd_n;
  assign peripheral_address_bus_o = cur.addr_bus;
  assign matched_mem_enable_o = cur.option[cfg_bank_pkg::OPT_MATCHED_BIT];
  assign data_ready_extend_o = cur.option[cfg_bank_pkg::OPT_RDY_EXT_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_version_read;
    rd_data && cur.index == cfg_bank_pkg::IDX_VERSION;
  endsequence

  sequence s_speed_read;
    rd_data && cur.index == cfg_bank_pkg::IDX_SPEED;
  endsequence

  sequence s_delayed_start;
    rst_n && cur.delay_mode && !cur.req_d1 && !cur.req_d2 && channel_cmd_req_i &&
      cur.phase == cfg_bank_pkg::CMD_IDLE;
  endsequence

  sequence s_strobe_late;
    fast_gfx_command_n_o ##1 !fast_gfx_command_n_o;
  endsequence

  a_busy_follow: assert property (@(posedge clk_i) disable iff (!rst_n)
    rst_n |=> cpu_busy_n_o == $past(coproc_busy_n_i))
    else $error("busy not forwarded");

  a_exception_follow: assert property (@(posedge clk_i) disable iff (!rst_n)
    rst_n && !coproc_error_n_i |=> !coproc_exception_n_o)
    else $error("exception not raised");

  a_sysreset_reset: assert property (@(posedge clk_i) disable iff (!rst_n)
    system_reset_third_i |=> coproc_reset_out_o)
    else $error("coprocessor reset missing on system reset");

  a_port_reset_pulse: assert property (@(posedge clk_i) disable iff (!rst_n)
    io_wr_i && hit(io_addr_i, cfg_bank_pkg::PORT_COPROC_RESET) |-> ##3 coproc_reset_out_o)
    else $error("port write gave no reset pulse");

  a_fast_needs_enable: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(cur.phase == cfg_bank_pkg::CMD_FAST) |->
      $past(cur.option[cfg_bank_pkg::OPT_FAST_GFX_BIT]) && !$past(fast_gfx_request_n_i))
    else $error("fast cycle without enable");

  a_default_match: assert property (@(posedge clk_i) disable iff (!rst_n)
    cur.phase != cfg_bank_pkg::CMD_FAST |-> channel_command_n_o == fast_gfx_command_n_o)
    else $error("strobes differ on default cycle");

  a_fast_only_gfx: assert property (@(posedge clk_i) disable iff (!rst_n)
    cur.phase == cfg_bank_pkg::CMD_FAST |-> channel_command_n_o && !fast_gfx_command_n_o)
    else $error("channel strobe on fast cycle");

  a_addr_latch: assert property (@(posedge clk_i) disable iff (!rst_n)
    !fast_gfx_command_n_o |-> peripheral_address_bus_o == $past(channel_addr_i))
    else $error("address not latched by strobe");

  a_version_ro: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_version_read |=> io_rdata_oe_o && io_rdata_o == {6'h00, cfg_bank_pkg::VERSION_REV})
    else $error("version read wrong");

  a_clock_write: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_data && cur.index == cfg_bank_pkg::IDX_SPEED |=>
      cpu_clock_sel_o == $past(io_wdata_i[1:0]))
    else $error("clock select not written");

  a_present_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
    cur.strap_taken |=> $stable(cur.present))
    else $error("presence bit changed");

  a_local_ready: assert property (@(posedge clk_i) disable iff (!rst_n)
    !cur.ready_from_coproc && coproc_cycle_i && !cur.ready_done && !$past(coproc_cycle_i)
      ##1 coproc_cycle_i |-> !cpu_ready_n_o ##1 cpu_ready_n_o)
    else $error("local ready pulse wrong");

  a_wide_delay: assert property (@(posedge clk_i) disable iff (!rst_n)
    $past(rst_n) && cur.delay_mode |=> cur.wide_sampled_n == $past(local_wide_mem_n_i, 2))
    else $error("wide sampling not delayed");

  a_strobe_delay: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_delayed_start |-> ##1 s_strobe_late)
    else $error("strobe not delayed");

  a_reserved_zero: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_speed_read |=> io_rdata_o[7] == 1'b0 && io_rdata_o[3:2] == 2'h0)
    else $error("reserved bits not zero");
endmodule
`default_nettype wire

/* logic/cfg_bank_pkg.sv */
// Constants and types shared by the configuration bank and its pulse timer
`default_nettype none
package cfg_bank_pkg;
  // I/O port addresses on the 10-bit peripheral address
  localparam logic [9:0] PORT_INDEX = 10'h022;
  localparam logic [9:0] PORT_DATA = 10'h023;
  localparam logic [9:0] PORT_COPROC_RESET = 10'h0F1;

  // Register indices written to the index port
  localparam logic [7:0] IDX_VERSION = 8'h8D;
  localparam logic [7:0] IDX_SPEED = 8'h8E;
  localparam logic [7:0] IDX_OPTION = 8'h8F;

  // Revision code, value is arbitrary
  localparam logic [1:0] VERSION_REV = 2'h2;

  // Speed select field positions and reset values
  localparam int SPD_CLK_LSB = 0;
  localparam int SPD_PRESENT_BIT = 4;
  localparam int SPD_READY_BIT = 5;
  localparam int SPD_DELAY_BIT = 6;
  localparam logic [1:0] SPD_CLK_RESET = 2'h0;
  localparam logic SPD_READY_RESET = 1'b1;
  localparam logic SPD_DELAY_RESET = 1'b1;

  // Processor clock select codes
  localparam logic [1:0] CLK_SEL_16MHZ = 2'h0;
  localparam logic [1:0] CLK_SEL_20MHZ = 2'h1;
  localparam logic [1:0] CLK_SEL_25MHZ = 2'h2;

  // Option select field positions and reset value
  localparam int OPT_MATCHED_BIT = 0;
  localparam int OPT_FAST_GFX_BIT = 1;
  localparam int OPT_RDY_EXT_BIT = 2;
  localparam logic [2:0] OPT_RESET = 3'h4;

  // Port-triggered coprocessor reset pulse, in clock cycles
  localparam int unsigned RESET_PULSE_DEFAULT = 32;
  localparam int PULSE_CNT_W = 8;

  // Command strobe phases
  typedef enum logic [1:0] {
    CMD_IDLE,
    CMD_DEFAULT,
    CMD_FAST
  } cmd_phase_e;
endpackage
`default_nettype wire

/* logic/pulse_timer_if.sv */
// Start and status wires between the bank and its reset pulse timer
`timescale 1ns/10ps
`default_nettype none
interface pulse_timer_if;
  logic start;
  logic active;
  modport owner (output start, input active);
  modport timer (input start, output active);
endinterface
`default_nettype wire

/* logic/coproc_reset_timer.sv */
// Retriggerable fixed-length pulse timer for the coprocessor reset
`timescale 1ns/10ps
`default_nettype none
module coproc_reset_timer #(
  parameter int unsigned PULSE_CYCLES = cfg_bank_pkg::RESET_PULSE_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  pulse_timer_if.timer tmr
);
  typedef struct packed {
    logic [cfg_bank_pkg::PULSE_CNT_W-1:0] count;
    logic active;
  } timer_state_s;

  localparam logic [cfg_bank_pkg::PULSE_CNT_W-1:0] LOAD =
    cfg_bank_pkg::PULSE_CNT_W'(PULSE_CYCLES);

  timer_state_s cur;
  timer_state_s next_cur;

  // A start while running reloads, so back-to-back writes stretch the pulse
  always_comb begin
    next_cur = cur;
    if (tmr.start) begin
      next_cur.count = LOAD;
    end else if (cur.count != '0) begin
      next_cur.count = cur.count - 1'b1;
    end
    next_cur.active = (next_cur.count != '0);
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign tmr.active = cur.active;

  // Every start reloads the full programmed count and raises the pulse
  a_pulse_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tmr.start |=> cur.active && cur.count == LOAD)
    else $error("reset pulse not loaded");
endmodule
`default_nettype wire

/* tb/coproc_gfx_model.sv */
// Behavioural coprocessor and graphics controller pins facing the bank
`timescale 1ns/10ps
`default_nettype none
module coproc_gfx_model (
  input wire logic busy_i,
  input wire logic error_i,
  input wire logic ready_i,
  input wire logic gfx_req_i,
  output logic coproc_busy_n_o,
  output logic coproc_error_n_o,
  output logic coproc_ready_n_o,
  output logic fast_gfx_request_n_o
);
  // Lines sit at their pulled-up level unless the model asserts them
  assign coproc_busy_n_o = !busy_i;
  // Error is held low for as long as an unmasked error stands
  assign coproc_error_n_o = !error_i;
  assign coproc_ready_n_o = !ready_i;
  // Request is held low through the whole command, the bank looks only when enabled
  assign fast_gfx_request_n_o = !gfx_req_i;
endmodule
`default_nettype wire

/* tb/cpu_bus_ctrl_config_test.sv */
// Self-checking bench for the configuration bank and its strobes
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_ctrl_config_test;
  // Short pulse keeps the run brief; expectations use the same figure
  localparam int unsigned N = 4;
  logic clk_i, rst_n_i, io_wr, io_rd, io_oe, busy_n, err_n, present, ccyc;
  logic rdy_n, rst3, cpu_busy_n, exc_n, np_rst, cpu_rdy_n, wait_ins, wide_n;
  logic wide_s_n, creq, gfx_req_n, chan_n, gfx_n, mm_en, rdy_ext;
  logic m_busy, m_err, m_rdy, m_gfx;
  logic [9:0] io_addr;
  logic [7:0] io_wdata, io_rdata, d;
  logic [1:0] clk_sel;
  logic [15:0] caddr, paddr;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  cpu_bus_ctrl_config #(.RESET_PULSE_CYCLES(N)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .io_addr_i(io_addr), .io_wr_i(io_wr),
    .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
    .io_rdata_oe_o(io_oe), .coproc_busy_n_i(busy_n), .coproc_error_n_i(err_n),
    .coproc_present_i(present), .coproc_cycle_i(ccyc), .coproc_ready_n_i(rdy_n),
    .system_reset_third_i(rst3), .cpu_busy_n_o(cpu_busy_n),
    .coproc_exception_n_o(exc_n), .coproc_reset_out_o(np_rst),
    .cpu_ready_n_o(cpu_rdy_n), .cpu_clock_sel_o(clk_sel),
    .local_wide_mem_n_i(wide_n), .local_wide_mem_sampled_n_o(wide_s_n),
    .bus_wait_insert_o(wait_ins), .channel_cmd_req_i(creq),
    .fast_gfx_request_n_i(gfx_req_n), .channel_command_n_o(chan_n),
    .fast_gfx_command_n_o(gfx_n), .channel_addr_i(caddr),
    .peripheral_address_bus_o(paddr), .matched_mem_enable_o(mm_en),
    .data_ready_extend_o(rdy_ext));

  coproc_gfx_model model (.busy_i(m_busy), .error_i(m_err), .ready_i(m_rdy),
    .gfx_req_i(m_gfx), .coproc_busy_n_o(busy_n), .coproc_error_n_o(err_n),
    .coproc_ready_n_o(rdy_n), .fast_gfx_request_n_o(gfx_req_n));

  //////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Inputs always move 1 ns after the rising edge, never on it
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  // Strobes are left up after an access; each access reassigns both and idle() drops them
  task automatic io(input logic wr, input logic [9:0] a, input logic [7:0] dat);
    io_addr = a;
    io_wdata = dat;
    io_wr = wr;
    io_rd = !wr;
    tick();
  endtask
  task automatic idle();
    io_wr = 1'b0;
    io_rd = 1'b0;
    tick();
  endtask
  task automatic regwr(input logic [7:0] idx, input logic [7:0] dat);
    io(1'b1, cfg_bank_pkg::PORT_INDEX, idx);
    io(1'b1, cfg_bank_pkg::PORT_DATA, dat);
    idle();
  endtask
  task automatic regrd(input logic [7:0] idx, output logic [7:0] dat);
    io(1'b1, cfg_bank_pkg::PORT_INDEX, idx);
    io(1'b0, cfg_bank_pkg::PORT_DATA, 8'h00);
    check("read enable", io_oe, 1'b1);
    dat = io_rdata;
    idle();
  endtask
  // Speed register image: presence strap in bit 4, reserved bits cleared
  function automatic logic [7:0] spd_exp(input logic [7:0] w);
    return {1'b0, w[6:5], present, 2'b00, w[1:0]};
  endfunction
  // Request held for two cycles; both strobes traced cycle by cycle
  task automatic strobe(input logic dm, input logic fen, input logic gfx);
    logic [15:0] a;
    int lo;
    int hi;
    a = 16'($urandom);
    caddr = a;
    m_gfx = gfx;
    lo = dm ? 2 : 1;
    hi = dm ? 4 : 2;
    for (int k = 0; k < 8; k++) begin
      check("gfx strobe", gfx_n, !(k >= lo && k <= hi));
      check("chan strobe", chan_n, (fen && gfx) || !(k >= lo && k <= hi));
      creq = (k < 2);
      tick();
    end
    m_gfx = 1'b0;
    check("latched address", paddr, a);
  endtask
  task automatic wide(input logic dm);
    logic [1:0] h;
    h = 2'b11;
    for (int k = 0; k < 12; k++) begin
      if (k > 2) check("wide sample", wide_s_n, dm ? h[1] : h[0]);
      wide_n = 1'($urandom);
      h = {h[0], wide_n};
      tick();
    end
  endtask
  // Coprocessor answers at random, fast or slow
  task automatic ready(input logic src);
    logic p;
    p = 1'b1;
    for (int k = 0; k < 6; k++) begin
      if (k > 0) check("cpu ready", cpu_rdy_n, src ? p : (k != 1));
      ccyc = (k < 5);
      m_rdy = 1'($urandom);
      p = !m_rdy;
      tick();
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n_i, io_wr, io_rd, ccyc, rst3, creq, m_busy, m_err, m_rdy, m_gfx} = 10'h000;
    {io_addr, io_wdata, caddr} = 34'h0;
    wide_n = 1'b1;
    present = 1'b1;
    void'($urandom(32'hDC6A));
    repeat (6) @(posedge clk_i);
    #1;
    check("reset np", np_rst, 1'b1);
    check("reset wait", wait_ins, 1'b1);
    rst_n_i = 1'b1;
    repeat (3) tick();
    regrd(cfg_bank_pkg::IDX_VERSION, d);
    check("version", d, {6'h00, cfg_bank_pkg::VERSION_REV});
    regrd(cfg_bank_pkg::IDX_SPEED, d);
    check("speed reset", d, spd_exp(8'h60));
    regrd(cfg_bank_pkg::IDX_OPTION, d);
    check("option reset", d, 8'h04);
    regwr(cfg_bank_pkg::IDX_VERSION, 8'hFF);
    regrd(cfg_bank_pkg::IDX_VERSION, d);
    check("version write", d, {6'h00, cfg_bank_pkg::VERSION_REV});
    regrd(8'h55, d);
    check("unknown index", d, 8'h00);
    io(1'b0, cfg_bank_pkg::PORT_INDEX, 8'h00);
    check("index read", io_rdata, 8'h55);
    io(1'b0, 10'h024, 8'h00);
    check("unmapped port", io_oe, 1'b0);
    idle();
    $display("register reset test done");
    for (int c = 0; c < 3; c++) begin
      logic [7:0] w;
      w = 8'($urandom);
      w[1:0] = 2'(c);
      regwr(cfg_bank_pkg::IDX_SPEED, w);
      check("clock select", clk_sel, w[1:0]);
      check("wait insert", wait_ins, w[6]);
      regrd(cfg_bank_pkg::IDX_SPEED, d);
      check("speed read", d, spd_exp(w));
    end
    for (int c = 0; c < 4; c++) begin
      logic [7:0] w;
      w = 8'($urandom);
      regwr(cfg_bank_pkg::IDX_OPTION, w);
      check("matched", mm_en, w[0]);
      check("ready extend", rdy_ext, w[2]);
      regrd(cfg_bank_pkg::IDX_OPTION, d);
      check("option read", d, {5'h00, w[2:0]});
    end
    $display("register write test done");
    for (int c = 0; c < 16; c++) begin
      {m_busy, m_err, rst3} = 3'($urandom);
      tick();
      check("busy", cpu_busy_n, !m_busy);
      check("exception", exc_n, !m_err);
      check("np reset", np_rst, rst3);
    end
    rst3 = 1'b0;
    io(1'b1, cfg_bank_pkg::PORT_COPROC_RESET, 8'($urandom));
    idle();
    tick();
    for (int c = 0; c < N; c++) begin
      check("np pulse", np_rst, 1'b1);
      tick();
    end
    check("np pulse end", np_rst, 1'b0);
    $display("sideband test done");
    for (int dm = 0; dm < 2; dm++) begin
      regwr(cfg_bank_pkg::IDX_SPEED, {1'b0, 1'(dm), 1'(dm), 5'h00});
      regwr(cfg_bank_pkg::IDX_OPTION, 8'h02);
      strobe(1'(dm), 1'b1, 1'b1);
      strobe(1'(dm), 1'b1, 1'b0);
      regwr(cfg_bank_pkg::IDX_OPTION, 8'h00);
      strobe(1'(dm), 1'b0, 1'b1);
      wide(1'(dm));
      ready(1'(dm));
      $display("strobe and ready test done");
    end
    // Second reset in mid-run with the strap low; presence must follow it
    present = 1'b0;
    rst_n_i = 1'b0;
    tick();
    check("reset np again", np_rst, 1'b1);
    rst_n_i = 1'b1;
    repeat (3) tick();
    regrd(cfg_bank_pkg::IDX_SPEED, d);
    check("strap low", d, spd_exp(8'h60));
    $display("second reset test done");
    end_sim();
  end
endmodule
`default_nettype wire
